// >>> hw/rfse_map.svh
// register map, field positions and reset values of the fault status and event block
// assumes a 32-bit classic Wishbone slave decoding byte addresses
`ifndef RFSE_MAP_SVH
`define RFSE_MAP_SVH
`define RFSE_OFS_STATUS   8'h34
`define RFSE_OFS_CONTROL  8'h38
`define RFSE_OFS_DATA     8'h3C
`define RFSE_OFS_ADDR     8'h40
`define RFSE_OFS_UADDR    8'h44
`define RFSE_OFS_RECFLAGS 8'h48
`define RFSE_OFS_IRQMASK  8'h4C
`define RFSE_NREC         8
`define RFSE_FRI_LSB      8
`define RFSE_ITE_BIT      6
`define RFSE_ICE_BIT      5
`define RFSE_IQE_BIT      4
`define RFSE_APF_BIT      3
`define RFSE_AFO_BIT      2
`define RFSE_PPF_BIT      1
`define RFSE_PFO_BIT      0
`define RFSE_IM_BIT       31
`define RFSE_IP_BIT       30
`define RFSE_IM_RST       1'h1
`define RFSE_IRQMASK_RST  7'h7F
`define RFSE_HAS_DEVTLB   1'h1
`define RFSE_HAS_QINV     1'h1
`define RFSE_HAS_AFL      1'h1
`define RFSE_HAS_XDATA    1'h1
`define RFSE_HAS_XADDR    1'h1
`endif

// >>> hw/rfse_pkg.sv
// types shared by the fault status and event block
// assumes the map header for sizes
package rfse_pkg;
  typedef enum logic [0:0] {
    RFSE_IDLE = 1'b0,
    RFSE_SEND = 1'b1
  } rfse_st_e;

  typedef struct packed {
    logic [63:0] addr;
    logic [31:0] data;
  } rfse_msg_s;

  typedef struct packed {
    logic fault;
    logic adv_rec0;
    logic adv_ovf;
    logic inv_queue_err;
    logic inv_completion_err;
    logic inv_timeout_err;
  } rfse_evt_s;
endpackage

// >>> hw/rfse_fault_event.sv
// fault status collection, record flags and fault-event message issue
// assumes event pulses on clk, a Wishbone master and a fabric port with valid/ready
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
`include "rfse_map.svh"
module rfse_fault_event (
  input  wire logic               clk,        // 200 MHz clock
  input  wire logic               sys_rst,    // ordinary reset, sync high
  input  wire logic               pg_rst,     // power-good reset, sync high
  input  wire logic               wb_cyc_i,   // bus cycle
  input  wire logic               wb_stb_i,   // strobe
  input  wire logic               wb_we_i,    // write
  input  wire logic [7:0]         wb_adr_i,   // byte address
  input  wire logic [3:0]         wb_sel_i,   // byte lanes
  input  wire logic [31:0]        wb_dat_i,   // write data
  output logic      [31:0]        wb_dat_o,   // read data
  output logic                    wb_ack_o,   // acknowledge
  input  wire rfse_pkg::rfse_evt_s evt,       // hardware event pulses
  output logic                    msg_valid,  // message write request
  input  wire logic               msg_ready,  // fabric takes message
  output rfse_pkg::rfse_msg_s     msg,        // message address and data
  output logic                    irq         // unmasked status level
);

  localparam int NREC = `RFSE_NREC;

  // bus slave state
  logic        ack_ff;
  logic        nxt_ack;
  logic [31:0] rdat_ff;
  logic [31:0] nxt_rdat;

  // sticky state
  logic [6:0]      sts_ff;
  logic [6:0]      nxt_sts;
  logic [NREC-1:0] recf_ff;
  logic [NREC-1:0] nxt_recf;
  logic [7:0]      fri_ff;
  logic [7:0]      nxt_fri;
  logic [2:0]      ptr_ff;
  logic [2:0]      nxt_ptr;
  logic            stage_ff;
  logic            nxt_stage;
  logic [2:0]      sidx_ff;
  logic [2:0]      nxt_sidx;

  // control state
  logic               im_ff;
  logic               nxt_im;
  logic               ip_ff;
  logic               nxt_ip;
  logic [31:0]        data_ff;
  logic [31:0]        nxt_data;
  logic [31:0]        addr_ff;
  logic [31:0]        nxt_addr;
  logic [31:0]        uaddr_ff;
  logic [31:0]        nxt_uaddr;
  logic [6:0]         imask_ff;
  logic [6:0]         nxt_imask;
  rfse_pkg::rfse_st_e st_ff;
  rfse_pkg::rfse_st_e nxt_st;
  rfse_pkg::rfse_msg_s msg_ff;
  rfse_pkg::rfse_msg_s nxt_msg;

  logic [31:0] bmask;
  logic [31:0] wv;
  logic        req;
  logic        wr;
  logic        primary_pending_fault;
  logic        any_old;
  logic        cond;
  logic        sent;
  logic [6:0]  sts_view;
  logic [6:0]  hw_set;

  assign bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wv    = wb_dat_i & bmask;
  assign req   = wb_cyc_i & wb_stb_i;
  // write takes effect at the edge where the master sees ack
  assign wr    = req & wb_we_i & ack_ff;
  assign primary_pending_fault   = |recf_ff;
  assign sent  = msg_valid & msg_ready;

  // visible status with the record OR in its slot
  always_comb begin
    sts_view = sts_ff;
    sts_view[`RFSE_PPF_BIT] = primary_pending_fault;
  end

  // ---------------- bus slave ----------------
  always_comb begin
    nxt_ack  = req & ~ack_ff;
    nxt_rdat = rdat_ff;
    if (req & ~ack_ff) begin
      unique case (wb_adr_i)
        `RFSE_OFS_STATUS:   nxt_rdat = {16'h0000, fri_ff, 1'b0, sts_view};
        `RFSE_OFS_CONTROL:  nxt_rdat = {im_ff, ip_ff, 30'h00000000};
        `RFSE_OFS_DATA:     nxt_rdat = data_ff;
        `RFSE_OFS_ADDR:     nxt_rdat = addr_ff;
        `RFSE_OFS_UADDR:    nxt_rdat = uaddr_ff;
        `RFSE_OFS_RECFLAGS: nxt_rdat = {24'h000000, recf_ff};
        `RFSE_OFS_IRQMASK:  nxt_rdat = {25'h0000000, imask_ff};
        default:            nxt_rdat = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst | pg_rst) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h00000000;
    end else begin
      ack_ff  <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // ---------------- status and records ----------------
  always_comb begin
    nxt_sts   = sts_ff;
    nxt_recf  = recf_ff;
    nxt_fri   = fri_ff;
    nxt_ptr   = ptr_ff;
    nxt_stage = 1'b0;
    nxt_sidx  = sidx_ff;
    hw_set    = 7'h00;
    // software clears first so that hardware sets win
    if (wr && wb_adr_i == `RFSE_OFS_STATUS) begin
      nxt_sts[`RFSE_ITE_BIT] = sts_ff[`RFSE_ITE_BIT] & ~wv[`RFSE_ITE_BIT];
      nxt_sts[`RFSE_ICE_BIT] = sts_ff[`RFSE_ICE_BIT] & ~wv[`RFSE_ICE_BIT];
      nxt_sts[`RFSE_IQE_BIT] = sts_ff[`RFSE_IQE_BIT] & ~wv[`RFSE_IQE_BIT];
      nxt_sts[`RFSE_APF_BIT] = sts_ff[`RFSE_APF_BIT] & ~wv[`RFSE_APF_BIT];
      nxt_sts[`RFSE_AFO_BIT] = sts_ff[`RFSE_AFO_BIT] & ~wv[`RFSE_AFO_BIT];
      nxt_sts[`RFSE_PFO_BIT] = sts_ff[`RFSE_PFO_BIT] & ~wv[`RFSE_PFO_BIT];
    end
    if (wr && wb_adr_i == `RFSE_OFS_RECFLAGS) begin
      nxt_recf = recf_ff & ~wv[NREC-1:0];
    end
    // second step of recording: flag follows captured details
    if (stage_ff) begin
      nxt_recf[sidx_ff] = 1'b1;
      if (!primary_pending_fault) begin
        nxt_fri = {5'h00, sidx_ff};
      end
    end
    // first step: claim a slot, or flag overflow
    if (evt.fault && !sts_ff[`RFSE_PFO_BIT]) begin
      if (recf_ff[ptr_ff] || (stage_ff && sidx_ff == ptr_ff)) begin
        nxt_sts[`RFSE_PFO_BIT] = 1'b1;
      end else begin
        nxt_stage = 1'b1;
        nxt_sidx  = ptr_ff;
        nxt_ptr   = ptr_ff + 3'h1;
      end
    end
    hw_set[`RFSE_ITE_BIT] = evt.inv_timeout_err & `RFSE_HAS_DEVTLB;
    hw_set[`RFSE_ICE_BIT] = evt.inv_completion_err & `RFSE_HAS_DEVTLB;
    hw_set[`RFSE_IQE_BIT] = evt.inv_queue_err & `RFSE_HAS_QINV;
    hw_set[`RFSE_APF_BIT] = evt.adv_rec0 & ~sts_ff[`RFSE_APF_BIT] & `RFSE_HAS_AFL;
    hw_set[`RFSE_AFO_BIT] = evt.adv_ovf & `RFSE_HAS_AFL;
    nxt_sts = nxt_sts | hw_set;
    nxt_sts[`RFSE_PPF_BIT] = 1'b0;
  end

  // only the power-good reset touches sticky state
  always_ff @(posedge clk) begin
    if (pg_rst) begin
      sts_ff   <= 7'h00;
      recf_ff  <= '0;
      fri_ff   <= 8'h00;
      ptr_ff   <= 3'h0;
      stage_ff <= 1'b0;
      sidx_ff  <= 3'h0;
    end else begin
      sts_ff   <= nxt_sts;
      recf_ff  <= nxt_recf;
      fri_ff   <= nxt_fri;
      ptr_ff   <= nxt_ptr;
      stage_ff <= nxt_stage;
      sidx_ff  <= nxt_sidx;
    end
  end

  // interrupt condition: a listed flag sets while everything was clear
  assign any_old = |sts_view;
  assign cond    = ~any_old & ((stage_ff & ~primary_pending_fault) | hw_set[`RFSE_APF_BIT]
                  | hw_set[`RFSE_IQE_BIT] | hw_set[`RFSE_ICE_BIT] | hw_set[`RFSE_ITE_BIT]);

  // ---------------- control and message ----------------
  always_comb begin
    nxt_im    = im_ff;
    nxt_ip    = ip_ff;
    nxt_data  = data_ff;
    nxt_addr  = addr_ff;
    nxt_uaddr = uaddr_ff;
    nxt_imask = imask_ff;
    nxt_st    = st_ff;
    nxt_msg   = msg_ff;
    if (wr) begin
      unique case (wb_adr_i)
        `RFSE_OFS_CONTROL: begin
          if (wb_sel_i[3]) begin
            nxt_im = wb_dat_i[`RFSE_IM_BIT];
          end
        end
        `RFSE_OFS_DATA: begin
          nxt_data = (data_ff & ~bmask) | wv;
          if (!`RFSE_HAS_XDATA) begin
            nxt_data[31:16] = 16'h0000;
          end
        end
        `RFSE_OFS_ADDR: begin
          nxt_addr = {((addr_ff[31:2] & ~bmask[31:2]) | wv[31:2]), 2'b00};
        end
        `RFSE_OFS_UADDR: begin
          nxt_uaddr = `RFSE_HAS_XADDR ? ((uaddr_ff & ~bmask) | wv) : 32'h00000000;
        end
        `RFSE_OFS_IRQMASK: begin
          nxt_imask = (imask_ff & ~bmask[6:0]) | wv[6:0];
        end
        default: begin
        end
      endcase
    end
    unique case (st_ff)
      rfse_pkg::RFSE_IDLE: begin
        if (ip_ff && !im_ff) begin
          nxt_st        = rfse_pkg::RFSE_SEND;
          nxt_msg.addr  = {uaddr_ff, addr_ff[31:2], 2'b00};
          nxt_msg.data  = data_ff;
        end
      end
      rfse_pkg::RFSE_SEND: begin
        if (msg_ready) begin
          nxt_st = rfse_pkg::RFSE_IDLE;
        end
      end
    endcase
    // pending clears when serviced; a fresh condition wins
    if (sent || !any_old) begin
      nxt_ip = 1'b0;
    end
    if (cond) begin
      nxt_ip = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst | pg_rst) begin
      im_ff    <= `RFSE_IM_RST;
      ip_ff    <= 1'b0;
      data_ff  <= 32'h00000000;
      addr_ff  <= 32'h00000000;
      uaddr_ff <= 32'h00000000;
      imask_ff <= `RFSE_IRQMASK_RST;
      st_ff    <= rfse_pkg::RFSE_IDLE;
      msg_ff   <= '0;
    end else begin
      im_ff    <= nxt_im;
      ip_ff    <= nxt_ip;
      data_ff  <= nxt_data;
      addr_ff  <= nxt_addr;
      uaddr_ff <= nxt_uaddr;
      imask_ff <= nxt_imask;
      st_ff    <= nxt_st;
      msg_ff   <= nxt_msg;
    end
  end

  assign msg_valid = (st_ff == rfse_pkg::RFSE_SEND);
  assign msg       = msg_ff;
  assign irq       = |(sts_view & ~imask_ff);

  // ---------------- checks ----------------
  fri_capture_a: assert property (@(posedge clk) disable iff (sys_rst | pg_rst)
    $rose(primary_pending_fault) |-> fri_ff == {5'h00, $past(sidx_ff)})
    else $error("first record index not captured");

  ovf_drop_a: assert property (@(posedge clk) disable iff (sys_rst | pg_rst)
    sts_ff[`RFSE_PFO_BIT] && evt.fault |=> !stage_ff)
    else $error("fault recorded during overflow");

  mask_blocks_a: assert property (@(posedge clk) disable iff (sys_rst | pg_rst)
    $rose(msg_valid) |-> !$past(im_ff))
    else $error("message launched while masked");

  cond_sets_ip_a: assert property (@(posedge clk) disable iff (sys_rst | pg_rst)
    cond |=> ip_ff)
    else $error("pending not set on condition");

  no_new_cond_a: assert property (@(posedge clk) disable iff (sys_rst | pg_rst)
    $rose(ip_ff) |-> !$past(any_old))
    else $error("pending rose with status already set");

  ip_held_a: assert property (@(posedge clk) disable iff (sys_rst | pg_rst)
    ip_ff && im_ff && any_old && !sent |=> ip_ff)
    else $error("pending dropped while held");

  ip_serviced_a: assert property (@(posedge clk) disable iff (sys_rst | pg_rst)
    sent && !cond |=> !ip_ff && !msg_valid)
    else $error("pending not cleared after send");

  msg_form_a: assert property (@(posedge clk) disable iff (sys_rst | pg_rst)
    $rose(msg_valid) |-> msg.addr[1:0] == 2'b00 && msg.addr[31:2] == $past(addr_ff[31:2]))
    else $error("message address malformed");

  flag_after_a: assert property (@(posedge clk) disable iff (sys_rst | pg_rst)
    stage_ff |=> recf_ff[$past(sidx_ff)])
    else $error("record flag not set after capture");

  bus_ack_a: assert property (@(posedge clk) disable iff (sys_rst | pg_rst)
    req && !ack_ff |=> ack_ff ##1 !ack_ff)
    else $error("ack not a single cycle after request");

endmodule // rfse_fault_event

// >>> verification/rfse_fabric_model.sv
// fabric end that accepts fault-event message writes
// assumes msg_valid holds with msg until it sees msg_ready at a clock edge
`timescale 1ns/1ps
module rfse_fabric_model (
  input  wire logic                clk,       // bench clock
  input  wire logic                rst,       // sync reset, high
  input  wire logic                msg_valid, // write request
  input  wire rfse_pkg::rfse_msg_s msg,       // address and data
  input  wire logic [3:0]          stall,     // msg_ready rises stall+1 cycles after msg_valid is seen
  output logic                     msg_ready, // accept
  output rfse_pkg::rfse_msg_s      got,       // last write taken
  output int                       got_cnt    // writes taken
);
  logic [3:0] wait_cnt;

  always @(posedge clk) begin
    if (rst) begin
      msg_ready <= 1'b0;
      wait_cnt  <= 4'h0;
      got       <= '0;
      got_cnt   <= 0;
    end else begin
      msg_ready <= 1'b0;
      if (msg_valid && msg_ready) begin
        // one write of data to the full address
        got      <= msg;
        got_cnt  <= got_cnt + 1;
        wait_cnt <= 4'h0;
      end else if (msg_valid) begin
        wait_cnt  <= wait_cnt + 4'h1;
        msg_ready <= (wait_cnt >= stall);
      end
    end
  end
endmodule // rfse_fabric_model

// >>> verification/tb.sv
// testbench of the fault status and event block
// assumes a Wishbone master, event pulses and the fabric model
`timescale 1ns/1ps
`include "rfse_map.svh"
module tb;
  logic                clk, sys_rst, pg_rst, cyc, stb, we, ack, irq, mv, mr;
  logic [7:0]          adr;
  logic [31:0]         wd, rd, q;
  logic [3:0]          stall, sel, lanes;
  rfse_pkg::rfse_evt_s evt;
  rfse_pkg::rfse_msg_s msg, got;
  int                  num_errors, total_checks, got_cnt, i, c;
  int                  sbit[5] = '{6, 5, 4, 2, 3};
  int                  cond[5] = '{1, 1, 1, 0, 1};

  rfse_fault_event u_dut (.clk(clk), .sys_rst(sys_rst), .pg_rst(pg_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
    .evt(evt), .msg_valid(mv), .msg_ready(mr), .msg(msg), .irq(irq));
  rfse_fabric_model u_fab (.clk(clk), .rst(pg_rst), .msg_valid(mv), .msg(msg), .stall(stall),
    .msg_ready(mr), .got(got), .got_cnt(got_cnt));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task tally_and_finish;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input string nm, input logic [95:0] s, input logic [95:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one classic cycle, released at the edge that shows ack
  // waits for ack with no limit of its own; only the watchdog ends a hang
  task rw(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= lanes;
    wd  <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    rw(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask

  task ev(input int b);
    @(posedge clk);
    evt <= rfse_pkg::rfse_evt_s'(6'h01 << b);
    @(posedge clk);
    evt <= '0;
    repeat (4) @(posedge clk);
  endtask

  task wait_cnt(input int e);
    for (int n = 0; n < 40 && got_cnt != e; n++) @(posedge clk);
  endtask

  task pulse_rst(input logic pg);
    @(posedge clk);
    if (pg) pg_rst <= 1'b1;
    else sys_rst <= 1'b1;
    @(posedge clk);
    pg_rst  <= 1'b0;
    sys_rst <= 1'b0;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end

  initial begin
    {cyc, stb, we, adr, wd, evt} = '0;
    sel = 4'h0;
    lanes = 4'hF;
    stall = 4'h3;
    sys_rst = 1'b1;
    pg_rst = 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    pg_rst  <= 1'b0;
    rdc(`RFSE_OFS_CONTROL, 32'h80000000, "control");
    rdc(`RFSE_OFS_STATUS, 32'h0, "status");
    rdc(8'h50, 32'h0, "unmapped");
    rw(1'b1, `RFSE_OFS_DATA, 32'h12345678);
    rw(1'b1, `RFSE_OFS_ADDR, 32'hFFFFFFFF);
    rw(1'b1, `RFSE_OFS_UADDR, 32'hFFFFFFFF);
    rdc(`RFSE_OFS_DATA, 32'h12345678, "data");
    rdc(`RFSE_OFS_ADDR, 32'hFFFFFFFC, "address");
    rdc(`RFSE_OFS_UADDR, 32'hFFFFFFFF, "upper address");
    $display("test registers done");
    ev(5);
    rdc(`RFSE_OFS_STATUS, 32'h00000002, "status");
    rdc(`RFSE_OFS_RECFLAGS, 32'h1, "record flags");
    rdc(`RFSE_OFS_CONTROL, 32'hC0000000, "control");
    chk("messages", 96'(got_cnt), 96'h0);
    @(negedge clk);
    chk("irq", irq, 1'b0);
    rw(1'b1, `RFSE_OFS_IRQMASK, 32'h7D);
    @(negedge clk);
    chk("irq", irq, 1'b1);
    rw(1'b1, `RFSE_OFS_CONTROL, 32'h0);
    wait_cnt(1);
    chk("messages", 96'(got_cnt), 96'h1);
    chk("message", got, {32'hFFFFFFFF, 32'hFFFFFFFC, 32'h12345678});
    rdc(`RFSE_OFS_CONTROL, 32'h0, "control");
    ev(5);
    rdc(`RFSE_OFS_STATUS, 32'h00000002, "status");
    wait_cnt(2);
    chk("messages", 96'(got_cnt), 96'h1);
    rw(1'b1, `RFSE_OFS_RECFLAGS, 32'h3);
    rdc(`RFSE_OFS_STATUS, 32'h0, "status");
    @(negedge clk);
    chk("irq", irq, 1'b0);
    $display("test fault message done");
    lanes = 4'h1;
    rw(1'b1, `RFSE_OFS_DATA, 32'hAAAAAAAA);
    lanes = 4'hF;
    rdc(`RFSE_OFS_DATA, 32'h123456AA, "data lanes");
    $display("test byte lanes done");
    c = 1;
    for (i = 0; i < 5; i++) begin
      ev(i);
      rdc(`RFSE_OFS_STATUS, 32'h1 << sbit[i], "status");
      c += cond[i];
      wait_cnt(c);
      chk("messages", 96'(got_cnt), 96'(c));
      rw(1'b1, `RFSE_OFS_STATUS, 32'hFF);
      rdc(`RFSE_OFS_STATUS, 32'h0, "status");
    end
    $display("test status events done");
    for (i = 0; i < 9; i++) ev(5);
    rdc(`RFSE_OFS_STATUS, 32'h00000203, "status");
    rw(1'b1, `RFSE_OFS_RECFLAGS, 32'hFF);
    ev(5);
    rdc(`RFSE_OFS_RECFLAGS, 32'h0, "record flags");
    rw(1'b1, `RFSE_OFS_STATUS, 32'h1);
    ev(5);
    rw(1'b0, `RFSE_OFS_STATUS, 32'h0);
    chk("status", q[7:0], 8'h02);
    $display("test overflow done");
    pulse_rst(1'b0);
    rw(1'b0, `RFSE_OFS_STATUS, 32'h0);
    chk("status", q[7:0], 8'h02);
    rdc(`RFSE_OFS_CONTROL, 32'h80000000, "control");
    pulse_rst(1'b1);
    rdc(`RFSE_OFS_STATUS, 32'h0, "status");
    rdc(`RFSE_OFS_RECFLAGS, 32'h0, "record flags");
    $display("test resets done");
    tally_and_finish();
  end
endmodule // tb
